// File: logic/sswc_consts.vh
// constants of the switch-array serial control block
// included by the design files; definitions only
`ifndef SSWC_CONSTS_VH
`define SSWC_CONSTS_VH
// register addresses
`define SSWC_ADDR_SW      7'h01
`define SSWC_ADDR_CFG     7'h02
`define SSWC_ADDR_FLAGS   7'h03
`define SSWC_ADDR_BURST   7'h05
`define SSWC_ADDR_KEY     7'h0b
`define SSWC_ADDR_CLEAR   7'h6c
`define SSWC_ADDR_DAISY   7'h25
// reset values
`define SSWC_RST_SW       8'h00
`define SSWC_RST_CFG      3'h6
`define SSWC_RST_FLAGS    3'h0
`define SSWC_RST_BURST    1'h0
`define SSWC_RST_KEY      8'h00
// bit positions of config enables and of error flags
`define SSWC_BIT_RW       2
`define SSWC_BIT_SCLK     1
`define SSWC_BIT_CRC      0
// frame figures
`define SSWC_LEN_PLAIN    5'h10
`define SSWC_LEN_CRC      5'h18
`define SSWC_ADDR_EDGE    5'h08
`define SSWC_CHECK_EDGE   5'h09
`define SSWC_ALIGN        8'h25
`define SSWC_CLEAR_FRAME  16'h6ca9
`define SSWC_DAISY_FRAME  16'h2500
`define SSWC_KEY_FIRST    8'ha3
`define SSWC_KEY_SECOND   8'h05
// crc
`define SSWC_CRC_POLY     8'h07
`define SSWC_CRC_SEED     8'h00
// initialization wait
`define SSWC_INIT_US      16'h0078
`define SSWC_CLK_MHZ      16'h0064
`define SSWC_INIT_W       16
`endif

// File: logic/sswc_crc8.v
// combinational crc-8 over a 16-bit payload, msb first
// assumes sswc_consts.vh on the include path
`timescale 1ns/10ps
`include "sswc_consts.vh"

module sswc_crc8 (
	// payload
	input  wire [15:0] data,
	// checksum
	output reg  [7:0]  crc
);
	integer i;
	reg     fb;

	always @*
	begin
		crc = `SSWC_CRC_SEED;
		fb  = 1'b0;
		for (i = 15; i >= 0; i = i - 1)
		begin
			fb  = crc[7] ^ data[i];
			crc = {crc[6:0], 1'b0} ^ (fb ? `SSWC_CRC_POLY : 8'h00);
		end
	end
endmodule // sswc_crc8

// File: logic/sswc_spi_ctrl.v
// serial control interface of an eight-switch array
// assumes cs_n, sclk, sdi come from another domain; sdo is open drain
`timescale 1ns/10ps
`include "sswc_consts.vh"

module sswc_spi_ctrl #(
	parameter [`SSWC_INIT_W-1:0] INIT_CYCLES = `SSWC_INIT_US * `SSWC_CLK_MHZ
) (
	// clock and reset
	input  wire       clock,
	input  wire       resetn,
	// serial pins
	input  wire       cs_n,
	input  wire       sclk,
	input  wire       sdi,
	output wire       sdo_out,
	output wire       sdo_oe,
	// switch drive and status
	output reg  [7:0] switch_state_reg,
	output reg        daisy_mode,
	output wire       init_busy
);
	// synchronisers
	reg  [1:0]  cs_sync;
	reg         cs_d;
	reg  [2:0]  sclk_sync;
	reg  [1:0]  sdi_sync;
	// registers
	reg  [2:0]  err_config;
	reg  [2:0]  err_flags;
	reg         burst_mode_control;
	reg  [7:0]  soft_reset_key;
	reg         key_armed;
	reg  [`SSWC_INIT_W-1:0] init_cnt;
	// frame state
	reg         active;
	reg  [4:0]  pos;
	reg         over;
	reg  [23:0] sh;
	reg         rw_q;
	reg  [6:0]  addr_q;
	reg  [7:0]  rdata_q;
	reg         cmd_bad;
	reg         sdo_bit;
	reg  [7:0]  dsr;
	reg         crc_q;
	// combinational
	reg  [4:0]  next_pos;
	reg         take;
	reg         at_end;
	reg         commit;
	reg         crc_ok;
	reg         good;
	reg         is_clear;
	reg         is_daisy;
	reg         do_wr;
	reg         sreset;
	reg  [15:0] payload;
	reg  [2:0]  set_flags;
	reg  [2:0]  next_flags;
	wire [23:0] nsh;
	wire [7:0]  rx_crc;
	wire [7:0]  tx_crc;
	wire [4:0]  len;
	wire [4:0]  k;
	wire        sel;
	wire        cs_fall;
	wire        cs_rise;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        sdi_bit;
	wire        crc_en;
	wire [6:0]  wr_addr;
	wire [7:0]  wr_data;
	wire [7:0]  align_byte;

	function [7:0] rd_reg;
		input [6:0] a;
		input [7:0] sw;
		input [2:0] cfg;
		input [2:0] flg;
		input       bst;
		input [7:0] key;
		begin
			case (a)
				`SSWC_ADDR_SW:    rd_reg = sw;
				`SSWC_ADDR_CFG:   rd_reg = {5'h00, cfg};
				`SSWC_ADDR_FLAGS: rd_reg = {5'h00, flg};
				`SSWC_ADDR_BURST: rd_reg = {7'h00, bst};
				`SSWC_ADDR_KEY:   rd_reg = key;
				default:          rd_reg = 8'h00;
			endcase
		end
	endfunction

	function addr_ok;
		input       rw;
		input [6:0] a;
		begin
			case (a)
				`SSWC_ADDR_SW, `SSWC_ADDR_CFG,
				`SSWC_ADDR_BURST, `SSWC_ADDR_KEY: addr_ok = 1'b1;
				`SSWC_ADDR_FLAGS:                  addr_ok = rw;
				`SSWC_ADDR_CLEAR, `SSWC_ADDR_DAISY: addr_ok = ~rw;
				default:                           addr_ok = 1'b0;
			endcase
		end
	endfunction

	// pins pass two flops; edges are found from the second and third stage
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cs_sync   <= 2'h3;
			cs_d      <= 1'b1;
			sclk_sync <= 3'h0;
			sdi_sync  <= 2'h0;
		end
		else
		begin
			cs_sync   <= {cs_sync[0], cs_n};
			cs_d      <= cs_sync[1];
			sclk_sync <= {sclk_sync[1:0], sclk};
			sdi_sync  <= {sdi_sync[0], sdi};
		end
	end

	assign sel       = ~cs_sync[1];
	assign cs_fall   = sel & cs_d;
	assign cs_rise   = cs_sync[1] & ~cs_d;
	assign sclk_rise = sel & sclk_sync[1] & ~sclk_sync[2];
	assign sclk_fall = sel & ~sclk_sync[1] & sclk_sync[2];
	assign sdi_bit   = sdi_sync[1];
	assign crc_en    = crc_q;
	assign align_byte = `SSWC_ALIGN;
	assign len       = crc_en ? `SSWC_LEN_CRC : `SSWC_LEN_PLAIN;
	assign nsh       = {sh[22:0], sdi_bit};
	assign wr_addr   = payload[14:8];
	assign wr_data   = payload[7:0];
	assign init_busy = (init_cnt != {`SSWC_INIT_W{1'b0}});
	assign k         = (pos == len) ? 5'h00 : pos;
	assign sdo_out   = 1'b0;
	assign sdo_oe    = sel & ~sdo_bit;

	// check byte expected for the received payload, and check byte of the read reply
	sswc_crc8 u_rx_crc (
		.data (nsh[23:8]),
		.crc  (rx_crc)
	);
	sswc_crc8 u_tx_crc (
		.data ({rw_q, addr_q, rdata_q}),
		.crc  (tx_crc)
	);

	always @*
	begin
		at_end   = (pos == len);
		take     = sclk_rise & active & ~daisy_mode & ~(at_end & ~burst_mode_control);
		next_pos = at_end ? 5'h01 : pos + 5'h01;
		commit   = take & (next_pos == len);
		payload  = crc_en ? nsh[23:8] : nsh[15:0];
		crc_ok   = ~crc_en | (rx_crc == nsh[7:0]);
		good     = commit & crc_ok;
		is_clear = good & (payload == `SSWC_CLEAR_FRAME);
		is_daisy = good & (payload == `SSWC_DAISY_FRAME);
		do_wr    = good & ~is_clear & ~is_daisy & ~payload[15] & ~cmd_bad;
		sreset   = do_wr & key_armed & (wr_addr == `SSWC_ADDR_KEY)
			& (wr_data == `SSWC_KEY_SECOND);
		set_flags = 3'h0;
		set_flags[`SSWC_BIT_RW] = take & (next_pos == `SSWC_CHECK_EDGE)
			& ~addr_ok(rw_q, addr_q) & err_config[`SSWC_BIT_RW];
		set_flags[`SSWC_BIT_CRC] = commit & ~crc_ok;
		set_flags[`SSWC_BIT_SCLK] = cs_rise & active & ~daisy_mode
			& err_config[`SSWC_BIT_SCLK] & (over | ~at_end);
		next_flags = (is_clear ? 3'h0 : err_flags) | set_flags;
	end

	// register file, software reset and initialization wait
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			err_config         <= `SSWC_RST_CFG;
			err_flags          <= `SSWC_RST_FLAGS;
			burst_mode_control <= `SSWC_RST_BURST;
			soft_reset_key     <= `SSWC_RST_KEY;
			key_armed          <= 1'b0;
			init_cnt           <= INIT_CYCLES;
			daisy_mode         <= 1'b0;
		end
		else if (sreset)
		begin
			err_config         <= `SSWC_RST_CFG;
			err_flags          <= `SSWC_RST_FLAGS;
			burst_mode_control <= `SSWC_RST_BURST;
			soft_reset_key     <= `SSWC_RST_KEY;
			key_armed          <= 1'b0;
			init_cnt           <= INIT_CYCLES;
		end
		else
		begin
			err_flags <= next_flags;
			if (init_busy)
				init_cnt <= init_cnt - {{(`SSWC_INIT_W-1){1'b0}}, 1'b1};
			if (is_daisy)
				daisy_mode <= 1'b1;
			if (commit)
				key_armed <= do_wr & (wr_addr == `SSWC_ADDR_KEY)
					& (wr_data == `SSWC_KEY_FIRST);
			if (do_wr)
			begin
				case (wr_addr)
					`SSWC_ADDR_CFG:   err_config <= wr_data[2:0];
					`SSWC_ADDR_BURST: burst_mode_control <= wr_data[0];
					`SSWC_ADDR_KEY:   soft_reset_key <= wr_data;
					default:          ;
				endcase
			end
		end
	end

	// switch state: written in address mode, loaded at chip select rise in daisy mode
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			switch_state_reg <= `SSWC_RST_SW;
		else if (sreset)
			switch_state_reg <= `SSWC_RST_SW;
		else if (daisy_mode & cs_rise & active)
			switch_state_reg <= dsr;
		else if (do_wr & (wr_addr == `SSWC_ADDR_SW))
			switch_state_reg <= wr_data;
	end

	// frame tracking and command capture
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			active  <= 1'b0;
			pos     <= 5'h00;
			over    <= 1'b0;
			sh      <= 24'h000000;
			rw_q    <= 1'b0;
			addr_q  <= 7'h00;
			rdata_q <= 8'h00;
			cmd_bad <= 1'b0;
			crc_q   <= 1'b0;
		end
		else if (cs_fall)
		begin
			active  <= ~init_busy;
			pos     <= 5'h00;
			over    <= 1'b0;
			cmd_bad <= 1'b0;
			crc_q   <= err_config[`SSWC_BIT_CRC];
		end
		else if (cs_rise)
			active <= 1'b0;
		else if (sclk_rise & active & ~daisy_mode)
		begin
			if (take)
			begin
				pos <= next_pos;
				sh  <= nsh;
				if (next_pos == `SSWC_ADDR_EDGE)
				begin
					rw_q    <= nsh[7];
					addr_q  <= nsh[6:0];
					rdata_q <= rd_reg(nsh[6:0], switch_state_reg, err_config,
						err_flags, burst_mode_control, soft_reset_key);
				end
				if (next_pos == `SSWC_CHECK_EDGE)
					cmd_bad <= ~addr_ok(rw_q, addr_q);
			end
			else
				over <= 1'b1;
		end
	end

	// daisy shifter: eight stages, kept across frames
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			dsr <= 8'h00;
		else if (is_daisy)
			dsr <= 8'h00;
		else if (daisy_mode & sclk_rise & active)
			dsr <= {dsr[6:0], sdi_bit};
	end

	// serial output, loaded at chip select fall, then changed on sclk fall
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			sdo_bit <= 1'b1;
		else if (cs_fall)
			sdo_bit <= daisy_mode ? dsr[7] : align_byte[7];
		else if (sclk_fall & active)
		begin
			if (daisy_mode)
				sdo_bit <= dsr[7];
			else if (at_end & ~burst_mode_control)
				sdo_bit <= 1'b1;
			else if (k < `SSWC_ADDR_EDGE)
				sdo_bit <= align_byte[~k[2:0]];
			else if (k < `SSWC_LEN_PLAIN)
				sdo_bit <= rdata_q[~k[2:0]];
			else
				sdo_bit <= tx_crc[~k[2:0]];
		end
	end
endmodule // sswc_spi_ctrl

// File: sim/sswc_host.sv
// host controller model: drives cs_n, sclk, sdi in mode 0
// assumes sdo resolved by the bench with a pull-up
`timescale 1ns/10ps
module sswc_host (
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input  wire  sdo
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end
	// crc-8 poly 0x07, seed 0, msb first
	function automatic [7:0] crc8(input [15:0] c);
		reg [7:0] k;
		k = 8'h00;
		for (int i = 15; i >= 0; i--)
			k = {k[6:0], 1'b0} ^ ((k[7] ^ c[i]) ? 8'h07 : 8'h00);
		return k;
	endfunction
	// n bits msb first from d; replies shift into r
	task automatic xfer(input [39:0] d, input int n, output [39:0] r);
		r = 40'h0;
		cs_n = 1'b0;
		#100;
		for (int i = 0; i < n; i++)
		begin
			sdi = d[39 - i];
			#62.5 sclk = 1'b1;
			r = {r[38:0], sdo};
			#62.5 sclk = 1'b0;
		end
		#100 cs_n = 1'b1;
		sdi = ~sdi;
		#100;
	endtask
endmodule // sswc_host

// File: sim/sswc_spi_ctrl_chk.sv
// checker of the switch-array serial block
// assumes it is bound to sswc_spi_ctrl
`timescale 1ns/10ps
module sswc_spi_ctrl_chk #(
	parameter [15:0] INIT_CYCLES = 16'd12000
) (
	input wire       clock,
	input wire       resetn,
	input wire       cs_n,
	input wire       sdo_out,
	input wire       sdo_oe,
	input wire [7:0] switch_state_reg,
	input wire       daisy_mode,
	input wire       init_busy
);
	logic [4:0]  cs_age;
	logic [15:0] busy_cnt;
	always @(posedge clock or negedge resetn)
		if (!resetn)
		begin
			cs_age   <= 5'h1f;
			busy_cnt <= 16'h0;
		end
		else
		begin
			cs_age   <= !cs_n ? 5'h0 : (cs_age == 5'h1f ? cs_age : cs_age + 5'h1);
			busy_cnt <= init_busy ? busy_cnt + 16'h1 : 16'h0;
		end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_OE_IN_FRAME: assert property (sdo_oe |-> cs_age < 5'd5)
		else $error("sdo driven outside a frame");
	AST_OD_ZERO: assert property (sdo_out == 1'b0)
		else $error("sdo value not low");
	AST_DAISY_KEEP: assert property (daisy_mode |=> daisy_mode)
		else $error("daisy mode left");
	AST_DAISY_ENTRY: assert property ($rose(daisy_mode) |-> cs_age < 5'd6 && !init_busy)
		else $error("daisy entry outside a frame");
	AST_SW_IN_FRAME: assert property (!$stable(switch_state_reg) |-> cs_age < 5'd8)
		else $error("switches changed outside a frame");
	AST_BUSY_FROZEN: assert property (init_busy && $past(init_busy, 3) |-> $stable(switch_state_reg))
		else $error("switches changed during init");
	AST_INIT_LEN: assert property ($fell(init_busy) |-> busy_cnt + 16'd1 >= INIT_CYCLES
		&& busy_cnt <= INIT_CYCLES + 16'd2) else $error("init wait length wrong");
	AST_SOFT_ZERO: assert property ($rose(init_busy) |-> ##[0:2] switch_state_reg == 8'h00)
		else $error("soft reset left switches set");
	COV_DAISY: cover property ($rose(daisy_mode));
	COV_SW: cover property (!$stable(switch_state_reg));
	COV_SOFT: cover property ($rose(init_busy));
endmodule // sswc_spi_ctrl_chk
bind sswc_spi_ctrl sswc_spi_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES)) i_chk (.clock(clock), .resetn(resetn),
	.cs_n(cs_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .switch_state_reg(switch_state_reg),
	.daisy_mode(daisy_mode), .init_busy(init_busy));

// File: sim/sswc_spi_ctrl_tb.sv
// testbench of the switch-array serial block
// assumes sswc_host as far side, sdo pulled up
`timescale 1ns/10ps
module sswc_spi_ctrl_tb;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        crc_on = 1'b0;
	logic [39:0] r;
	int          err_count = 0;
	int          n_compared = 0;
	wire         cs_n, sclk, sdi, sdo_out, sdo_oe, daisy_mode, init_busy;
	wire [7:0]   sw;
	wire         sdo = sdo_oe ? sdo_out : 1'b1;
	always #5 clock = ~clock;
	sswc_host i_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
	sswc_spi_ctrl #(.INIT_CYCLES(16'd20)) i_dut (.clock(clock), .resetn(resetn), .cs_n(cs_n),
		.sclk(sclk), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .switch_state_reg(sw),
		.daisy_mode(daisy_mode), .init_busy(init_busy));
	task chk(input [39:0] got, input [39:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmd(input [15:0] c, input int n = 16, input bad = 1'b0);
		i_host.xfer({c, crc_on ? i_host.crc8(c) ^ {8{bad}} : 8'h00, 16'h0}, crc_on && n == 16 ? 24 : n, r);
	endtask
	task rdchk(input [6:0] a, input [7:0] exp);
		cmd({1'b1, a, 8'h00});
		chk(crc_on ? r[15:8] : r[7:0], exp);
	endtask
	task ready;
		for (int i = 0; i < 200 && init_busy !== 1'b0; i++)
			@(posedge clock);
		repeat (4) @(posedge clock);
		#2;
	endtask
	task t_addr;
		cmd(16'h015a);
		chk(r[15:8], 8'h25);
		chk(sw, 8'h5a);
		cmd(16'h01ff, 12);
		chk(sw, 8'h5a);
		cmd(16'h0133, 20);
		chk(sw, 8'h33);
		rdchk(7'h03, 8'h02);
		cmd(16'h0300);
		cmd(16'h8000);
		rdchk(7'h03, 8'h06);
		cmd(16'h6ca9);
		rdchk(7'h03, 8'h00);
		rdchk(7'h02, 8'h06);
		cmd(16'h0202);
		cmd(16'h8000);
		rdchk(7'h03, 8'h00);
		cmd(16'h0206);
		$display("t_addr done");
	endtask
	task t_crc;
		cmd(16'h0207);
		crc_on = 1'b1;
		cmd(16'h0177, 16, 1'b1);
		chk(sw, 8'h33);
		rdchk(7'h03, 8'h01);
		cmd(16'h6ca9, 16, 1'b1);
		rdchk(7'h03, 8'h01);
		cmd(16'h6ca9);
		rdchk(7'h03, 8'h00);
		chk(r[7:0], i_host.crc8(16'h8300));
		cmd(16'h0206);
		crc_on = 1'b0;
		$display("t_crc done");
	endtask
	task t_burst;
		cmd(16'h0501);
		i_host.xfer({16'h01a5, 16'h8100, 8'h00}, 32, r);
		chk({r[31:24], r[15:0]}, 24'h2525a5);
		i_host.xfer({16'h8300, 16'h8300, 8'h00}, 40, r);
		rdchk(7'h03, 8'h02);
		cmd(16'h6ca9);
		$display("t_burst done");
	endtask
	task t_soft;
		cmd(16'h0ba3);
		cmd(16'h0b05);
		chk(sw, 8'h00);
		ready;
		rdchk(7'h05, 8'h00);
		$display("t_soft done");
	endtask
	task t_daisy;
		cmd(16'h2500);
		chk(daisy_mode, 1'b1);
		cmd(16'h1234);
		chk({r[15:0], sw}, 24'h001234);
		cmd(16'habc0, 12);
		chk({r[11:0], sw}, 20'h34abc);
		cmd(16'h0215);
		chk({daisy_mode, sw}, 9'h115);
		@(posedge clock) resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		ready;
		chk({daisy_mode, sw}, 9'h000);
		$display("t_daisy done");
	endtask
	task print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		ready;
		t_addr;
		t_crc;
		t_burst;
		t_soft;
		t_daisy;
		print_verdict;
	end
	initial
	begin
		#500000;
		err_count++;
		print_verdict;
	end
endmodule // sswc_spi_ctrl_tb
